/* File: include/dat_pkg.sv */
package dat_pkg;

    // Timebase and the zero-crossing wait window.
    localparam int CLK_HZ = 40_000_000;
    localparam int ZC_WINDOW_MS = 50;
    localparam int ZC_WINDOW_CYC = CLK_HZ / 1000 * ZC_WINDOW_MS;

    // Device type code of the address byte; the value is arbitrary.
    localparam logic [3:0] TYPE_CODE_DEF = 4'ha;

    // Command bytes of a write transfer.
    localparam logic [7:0] CMD_WR0 = 8'ha9;
    localparam logic [7:0] CMD_WR1 = 8'haa;
    localparam logic [7:0] CMD_WRB = 8'haf;
    localparam logic [7:0] CMD_ZC_ON = 8'hbd;
    localparam logic [7:0] CMD_ZC_OFF = 8'hbe;

    // Wiper register layout and power-up value.
    localparam logic [7:0] WIPER_RESET = 8'h3f;
    localparam int MUTE_BIT = 6;
    localparam int POS_W = 6;
    localparam logic [6:0] MUTE_POS = 7'h40;

    // Byte framing and byte positions inside one transfer.
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [2:0] IDX_ADDR = 3'h0;
    localparam logic [2:0] IDX_CMD = 3'h1;
    localparam logic [2:0] IDX_DATA0 = 3'h2;
    localparam logic [2:0] IDX_DATA1 = 3'h3;
    localparam logic [2:0] IDX_MAX = 3'h4;
    localparam logic RW_READ = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_ACK,
        ST_TX,
        ST_TXACK
    } dat_state_e;

    // Wiper register to applied tap: bit 6 forces mute, bit 7 is ignored.
    function automatic logic [6:0] dat_decode(input logic [7:0] val);
        dat_decode = val[MUTE_BIT] ? MUTE_POS : {1'b0, val[POS_W-1:0]};
    endfunction

endpackage

/* File: logic/dat_zc_gate.sv */
module dat_zc_gate import dat_pkg::*; #(
    parameter int WIN_CYC = ZC_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic gate_en,
    input wire logic load,
    input wire logic [7:0] load_val,
    input wire logic equal,
    output logic [6:0] pos_reg,
    output logic pending_reg
);

    localparam int TMR_W = $clog2(WIN_CYC + 1);
    localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(WIN_CYC - 1);

    logic [7:0] pend_val_reg;
    logic [TMR_W-1:0] tmr_reg;

    // A new write restarts the window, so the latest value always wins.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_reg <= 1'b0;
            tmr_reg <= '0;
            pend_val_reg <= WIPER_RESET;
        end else if (load && gate_en) begin
            pending_reg <= 1'b1;
            tmr_reg <= '0;
            pend_val_reg <= load_val;
        end else if (load) begin
            pending_reg <= 1'b0;
        end else if (pending_reg) begin
            if (equal || tmr_reg == TMR_LAST) begin
                pending_reg <= 1'b0;
            end
            tmr_reg <= tmr_reg + TMR_W'(1);
        end
    end

    // Applied tap moves now when gating is off, else on crossing or timeout.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_reg <= dat_decode(WIPER_RESET);
        end else if (load && !gate_en) begin
            pos_reg <= dat_decode(load_val);
        end else if (!load && pending_reg &&
                     (equal || tmr_reg == TMR_LAST)) begin
            pos_reg <= dat_decode(pend_val_reg);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_immediate_apply: assert property (
        load && !gate_en |=> pos_reg == dat_decode($past(load_val)))
        else $error("wiper not applied at once with gating off");
    a_window_start: assert property (
        load && gate_en |=> pending_reg && tmr_reg == '0)
        else $error("wait window did not start on write");
    a_timeout_forced: assert property (
        pending_reg && !load && tmr_reg == TMR_LAST
        |=> !pending_reg && pos_reg == dat_decode($past(pend_val_reg)))
        else $error("pending value not forced at window end");
    a_wait_crossing: assert property (
        pending_reg && !equal && !load && tmr_reg != TMR_LAST
        |=> pending_reg && $stable(pos_reg))
        else $error("wiper moved without a crossing");

endmodule // dat_zc_gate

/* File: logic/dat_i2c_slave.sv */
// Contract
// - Gated update waits for equal terminals, per pot.
// - Wait window starts at write acknowledge.
// - Window expiry forces the pending value.
// - Ungated write applies right after acknowledge.
// - Gating is enabled out of power-up.
// - Data falling with clock high means START.
// - Data rising with clock high means STOP.
// - Data changes only while clock low.
// - Bytes followed by a ninth acknowledge bit.
// - Acknowledger holds data low through clock high.
// - Master nack releases data for STOP.
// - Works at 100 kHz and 400 kHz.
// - Address is type code, selects, direction.
// - Acknowledge only matching type and select pins.
// - Direction one reads, zero writes.
// - Bytes go MSB first; receiver acknowledges.
// - Read sends wiper 0, then wiper 1.
// - Command byte encodings for wiper writes.
// - Command selects which wipers take data.
// - Command and every data byte acknowledged; an unknown command gets no ack.
// - Repeated START restarts address recognition.
// - Bits 0-5 position, bit 6 mutes.
// - Power-up loads position 63 in both.
// - Commands enable or disable zero-crossing gating.
module dat_i2c_slave import dat_pkg::*; #(
    parameter logic [3:0] TYPE_CODE = TYPE_CODE_DEF,
    parameter int WIN_CYC = ZC_WINDOW_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic select_pin_bit0,
    input wire logic select_pin_bit1,
    input wire logic select_pin_bit2,
    input wire logic [1:0] terminals_equal,
    output logic [6:0] wiper_pos0,
    output logic [6:0] wiper_pos1,
    output logic [1:0] wiper_pending,
    output logic zc_enabled
);

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [6:0] pin_meta_reg;
    logic [6:0] pin_sync_reg;
    logic scl_s, sda_s, scl_d_reg, sda_d_reg;
    logic [2:0] sel_s;
    logic [1:0] eq_s;
    logic scl_rise, scl_fall, start_cond, stop_cond;
    dat_state_e state_reg;
    logic [3:0] cnt_reg;
    logic [2:0] idx_reg;
    logic [7:0] sh_reg;
    logic [7:0] tx_reg;
    logic tx_sel_reg;
    logic rw_reg;
    logic mack_reg;
    logic sda_oe_reg;
    logic [7:0] cmd_reg;
    logic [7:0] wreg0_reg, wreg1_reg;
    logic [1:0] load_reg;
    logic [7:0] load_val0_reg, load_val1_reg;
    logic zc_on_reg;
    logic byte_done, accept, ack_end, cmd_ok;
    logic [6:0] pos_w [2];

    // Reset is released through two flip-flops.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // Every pin crosses two flops; the first stage feeds only the second.
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_sync
            logic pin;
            if (gi == 0) begin : g_scl
                assign pin = scl;
            end else if (gi == 1) begin : g_sda
                assign pin = sda_in;
            end else if (gi == 2) begin : g_s0
                assign pin = select_pin_bit0;
            end else if (gi == 3) begin : g_s1
                assign pin = select_pin_bit1;
            end else if (gi == 4) begin : g_s2
                assign pin = select_pin_bit2;
            end else begin : g_eq
                assign pin = terminals_equal[gi-5];
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    pin_meta_reg[gi] <= 1'b1;
                    pin_sync_reg[gi] <= 1'b1;
                end else begin
                    pin_meta_reg[gi] <= pin;
                    pin_sync_reg[gi] <= pin_meta_reg[gi];
                end
            end
        end
    endgenerate
    assign scl_s = pin_sync_reg[0];
    assign sda_s = pin_sync_reg[1];
    assign sel_s = pin_sync_reg[4:2];
    assign eq_s = pin_sync_reg[6:5];

    // Previous samples for edge and bus-condition detection.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
        end
    end

    // Oversampling at 40 MHz leaves 100 clocks per 400 kHz bit.
    assign scl_rise = scl_s && !scl_d_reg;
    assign scl_fall = !scl_s && scl_d_reg;
    assign start_cond = scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_cond = scl_s && scl_d_reg && !sda_d_reg && sda_s;

    // Byte completion after eight clocks, then the acknowledge decision.
    assign byte_done = state_reg == ST_RX && scl_fall && cnt_reg == BYTE_BITS;
    assign cmd_ok = sh_reg == CMD_WR0 || sh_reg == CMD_WR1 ||
                    sh_reg == CMD_WRB || sh_reg == CMD_ZC_ON ||
                    sh_reg == CMD_ZC_OFF;
    always_comb begin
        if (idx_reg == IDX_ADDR) begin
            accept = sh_reg[7:4] == TYPE_CODE && sh_reg[3:1] == sel_s;
        end else if (idx_reg == IDX_CMD) begin
            accept = cmd_ok;
        end else begin
            accept = 1'b1;
        end
    end
    assign ack_end = state_reg == ST_ACK && scl_fall;

    // Serial protocol engine; START and STOP override any state.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 4'h0;
            idx_reg <= IDX_ADDR;
            sh_reg <= 8'h00;
            tx_reg <= 8'h00;
            tx_sel_reg <= 1'b0;
            rw_reg <= 1'b0;
            mack_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
        end else if (start_cond) begin
            state_reg <= ST_RX;
            cnt_reg <= 4'h0;
            idx_reg <= IDX_ADDR;
            sda_oe_reg <= 1'b0;
        end else if (stop_cond) begin
            state_reg <= ST_IDLE;
            sda_oe_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_RX: begin
                    if (scl_rise) begin
                        sh_reg <= {sh_reg[6:0], sda_s};
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (byte_done) begin
                        cnt_reg <= 4'h0;
                        sda_oe_reg <= accept;
                        state_reg <= accept ? ST_ACK : ST_IDLE;
                        if (idx_reg == IDX_ADDR) begin
                            rw_reg <= sh_reg[0];
                        end
                    end
                end
                ST_ACK: begin
                    if (ack_end) begin
                        if (idx_reg != IDX_MAX) begin
                            idx_reg <= idx_reg + 3'h1;
                        end
                        if (rw_reg == RW_READ) begin
                            tx_reg <= wreg0_reg;
                            tx_sel_reg <= 1'b1;
                            sda_oe_reg <= !wreg0_reg[7];
                            state_reg <= ST_TX;
                        end else begin
                            sda_oe_reg <= 1'b0;
                            state_reg <= ST_RX;
                        end
                    end
                end
                ST_TX: begin
                    if (scl_rise) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end
                    if (scl_fall && cnt_reg == BYTE_BITS) begin
                        cnt_reg <= 4'h0;
                        sda_oe_reg <= 1'b0;
                        state_reg <= ST_TXACK;
                    end else if (scl_fall) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sda_oe_reg <= !tx_reg[6];
                    end
                end
                ST_TXACK: begin
                    if (scl_rise) begin
                        mack_reg <= !sda_s;
                    end
                    if (scl_fall && mack_reg) begin
                        tx_reg <= tx_sel_reg ? wreg1_reg : wreg0_reg;
                        sda_oe_reg <= tx_sel_reg ? !wreg1_reg[7]
                                                 : !wreg0_reg[7];
                        tx_sel_reg <= !tx_sel_reg;
                        state_reg <= ST_TX;
                    end else if (scl_fall) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    sda_oe_reg <= 1'b0;
                end
                default: begin
                    state_reg <= ST_IDLE;
                    sda_oe_reg <= 1'b0;
                end
            endcase
        end
    end

    // Command and data bytes take effect when their acknowledge ends.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_reg <= 8'h00;
            wreg0_reg <= WIPER_RESET;
            wreg1_reg <= WIPER_RESET;
            load_reg <= 2'h0;
            load_val0_reg <= WIPER_RESET;
            load_val1_reg <= WIPER_RESET;
            zc_on_reg <= 1'b1;
        end else begin
            load_reg <= 2'h0;
            if (ack_end && rw_reg != RW_READ && !start_cond && !stop_cond) begin
                if (idx_reg == IDX_CMD) begin
                    cmd_reg <= sh_reg;
                    if (sh_reg == CMD_ZC_ON) begin
                        zc_on_reg <= 1'b1;
                    end else if (sh_reg == CMD_ZC_OFF) begin
                        zc_on_reg <= 1'b0;
                    end
                end else if (idx_reg == IDX_DATA0) begin
                    if (cmd_reg == CMD_WR0 || cmd_reg == CMD_WRB) begin
                        wreg0_reg <= sh_reg;
                        load_reg[0] <= 1'b1;
                        load_val0_reg <= sh_reg;
                    end
                    if (cmd_reg == CMD_WR1 || cmd_reg == CMD_WRB) begin
                        wreg1_reg <= sh_reg;
                        load_reg[1] <= 1'b1;
                        load_val1_reg <= sh_reg;
                    end
                end else if (idx_reg == IDX_DATA1 && cmd_reg == CMD_WR0) begin
                    wreg1_reg <= sh_reg;
                    load_reg[1] <= 1'b1;
                    load_val1_reg <= sh_reg;
                end
            end
        end
    end

    // One gate per potentiometer so each waits on its own terminals.
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pot
            dat_zc_gate #(
                .WIN_CYC(WIN_CYC)
            ) u_gate (
                .clk(clk),
                .rst_n(rst_n),
                .gate_en(zc_on_reg),
                .load(load_reg[gi]),
                .load_val(gi == 0 ? load_val0_reg : load_val1_reg),
                .equal(eq_s[gi]),
                .pos_reg(pos_w[gi]),
                .pending_reg(wiper_pending[gi])
            );
        end
    endgenerate
    assign wiper_pos0 = pos_w[0];
    assign wiper_pos1 = pos_w[1];

    // The pin is open drain: output low, enabled only to pull low.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end
    assign sda_oe = sda_oe_reg;
    assign zc_enabled = zc_on_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_start_restart: assert property (
        start_cond |=> state_reg == ST_RX && idx_reg == IDX_ADDR && !sda_oe)
        else $error("START did not restart address recognition");
    a_stop_idle: assert property (
        stop_cond && !start_cond |=> state_reg == ST_IDLE && !sda_oe)
        else $error("STOP did not end the transfer");
    a_foreign_addr: assert property (
        byte_done && idx_reg == IDX_ADDR && !accept && !start_cond
        && !stop_cond |=> state_reg == ST_IDLE && !sda_oe)
        else $error("acknowledged a foreign address");
    a_ack_holds: assert property (
        state_reg == ST_ACK && !scl_fall && !start_cond && !stop_cond
        |=> sda_oe)
        else $error("acknowledge released early");
    a_read_msb: assert property (
        ack_end && rw_reg && !start_cond && !stop_cond
        |=> state_reg == ST_TX && sda_oe == !$past(wreg0_reg[7]))
        else $error("read did not start with wiper 0 MSB");
    a_nack_release: assert property (
        state_reg == ST_TXACK && scl_fall && !mack_reg && !start_cond
        && !stop_cond |=> state_reg == ST_IDLE && !sda_oe)
        else $error("line not released after master nack");
    a_steady_high: assert property (
        scl_s && scl_d_reg |=> $stable(sda_oe) || $past(start_cond)
        || $past(stop_cond))
        else $error("data changed while clock high");
    a_zc_off_cmd: assert property (
        ack_end && !rw_reg && idx_reg == IDX_CMD && sh_reg == CMD_ZC_OFF
        && !start_cond && !stop_cond |=> !zc_enabled)
        else $error("gating not disabled by command");

endmodule // dat_i2c_slave

/* File: testbench/dat_bus_master.sv */
// Bus master model: it drives the clock and its own pull on the data line.
module dat_bus_master (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;

    // Both lines idle high, and the clock stands still between frames.
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // START from idle, or a repeated START entered with the clock low.
    // The clock rises only after the slave has dropped its acknowledge, so
    // it never rises over a held low and no false STOP is seen.
    task automatic start();
        #50 sda_m = 1'b1;
        #50 scl = 1'b1;
        #50 sda_m = 1'b0;
        #50 scl = 1'b0;
    endtask

    // STOP: data rises while the clock is high, leaving the bus idle.
    task automatic stop();
        #50 sda_m = 1'b0;
        #50 scl = 1'b1;
        #50 sda_m = 1'b1;
        #50;
    endtask

    // One bit: data moves only in the low phase, and is read at the end of
    // the high phase so that the slave's lagging view has settled.
    task automatic bit_xfer(input logic b, output logic r);
        #50 sda_m = b;
        #50 scl = 1'b1;
        #100 r = sda;
        scl = 1'b0;
    endtask

    // Byte out MSB first; the line is released for the slave's ninth bit.
    task automatic wbyte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], r);
        end
        bit_xfer(1'b1, ack);
    endtask

    // Byte in; the master acknowledges unless this is its last byte.
    task automatic rbyte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(last, r);
    endtask
endmodule // dat_bus_master

/* File: testbench/dat_i2c_slave_tb.sv */
module dat_i2c_slave_tb import dat_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int WIN = 200;
    localparam logic [2:0] SEL = 3'h5;
    logic clk, nrst, scl, sda_m, sda_out, sda_oe, zc_enabled;
    logic [1:0] terminals_equal, wiper_pending;
    logic [6:0] wiper_pos0, wiper_pos1;
    logic [7:0] d;
    logic a;
    wire logic sda;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    // The wire is pulled up; an enabled device driver can only pull it low,
    // so a device that drove high while enabled would break the acks.
    assign sda = sda_m & ~(sda_oe & ~sda_out);

    dat_bus_master m (.scl(scl), .sda_m(sda_m), .sda(sda));

    dat_i2c_slave #(.TYPE_CODE(TYPE_CODE_DEF), .WIN_CYC(WIN)) DUT (
        .clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .select_pin_bit0(SEL[0]), .select_pin_bit1(SEL[1]),
        .select_pin_bit2(SEL[2]), .terminals_equal(terminals_equal),
        .wiper_pos0(wiper_pos0), .wiper_pos1(wiper_pos1),
        .wiper_pending(wiper_pending), .zc_enabled(zc_enabled));

    // Clock with rising edges on multiples of 25 ns; bus inputs move on the falling edges between them.
    initial begin
        clk = 1'b0;
        #12.5;
        forever #12.5 clk = ~clk;
    end

    // A hung handshake would stall the run, so cycles are capped.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask

    // Write transfer with n data bytes; the command ack is compared.
    task automatic wr(input logic [7:0] cmd, d0, d1, input int n,
                      input logic cmd_ack);
        m.start();
        m.wbyte({TYPE_CODE_DEF, SEL, 1'b0}, a);
        chk("addr ack", 8'h0, {7'h0, a});
        m.wbyte(cmd, a);
        chk("cmd ack", {7'h0, cmd_ack}, {7'h0, a});
        for (int i = 0; i < n; i++) begin
            m.wbyte(i == 0 ? d0 : d1, a);
            chk("data ack", 8'h0, {7'h0, a});
        end
        m.stop();
        repeat (2) @(negedge clk);
    endtask

    // Read both registers; the device lets go after the master's nack.
    task automatic rd(input logic [7:0] e0, e1);
        m.start();
        m.wbyte({TYPE_CODE_DEF, SEL, RW_READ}, a);
        chk("read addr ack", 8'h0, {7'h0, a});
        m.rbyte(1'b0, d);
        chk("read byte0", e0, d);
        m.rbyte(1'b1, d);
        chk("read byte1", e1, d);
        repeat (6) @(negedge clk);
        chk("sda released", 8'h0, {7'h0, sda_oe});
        m.stop();
    endtask

    task automatic t_reset();
        chk("pos0", WIPER_RESET, {1'b0, wiper_pos0});
        chk("pos1", WIPER_RESET, {1'b0, wiper_pos1});
        chk("zc on", 8'h1, {7'h0, zc_enabled});
        chk("pending", 8'h0, {6'h0, wiper_pending});
        $display("test reset done");
    endtask

    // Wrong select, wrong type code and an unknown command are refused.
    task automatic t_refuse();
        m.start();
        m.wbyte({TYPE_CODE_DEF, SEL ^ 3'h1, 1'b0}, a);
        chk("wrong select", 8'h1, {7'h0, a});
        m.wbyte(CMD_ZC_OFF, a);
        chk("ignored byte", 8'h1, {7'h0, a});
        m.stop();
        chk("zc kept", 8'h1, {7'h0, zc_enabled});
        m.start();
        m.wbyte({~TYPE_CODE_DEF, SEL, 1'b0}, a);
        chk("wrong type", 8'h1, {7'h0, a});
        m.stop();
        wr(8'h55, 8'h0, 8'h0, 0, 1'b1);
        $display("test refuse done");
    endtask

    // Ungated write of both wipers through one command; bit 6 mutes.
    task automatic t_direct();
        wr(CMD_ZC_OFF, 8'h0, 8'h0, 0, 1'b0);
        chk("zc off", 8'h0, {7'h0, zc_enabled});
        wr(CMD_WR0, 8'h05, 8'h47, 2, 1'b0);
        chk("pos0", 8'h05, {1'b0, wiper_pos0});
        chk("pos1 mute", 8'h40, {1'b0, wiper_pos1});
        rd(8'h05, 8'h47);
        $display("test direct done");
    endtask

    // Both-wipers write, then a repeated START straight into a read.
    task automatic t_both();
        m.start();
        m.wbyte({TYPE_CODE_DEF, SEL, 1'b0}, a);
        m.wbyte(CMD_WRB, a);
        m.wbyte(8'haa, a);
        chk("both ack", 8'h0, {7'h0, a});
        rd(8'haa, 8'haa);
        chk("pos0", 8'h2a, {1'b0, wiper_pos0});
        chk("pos1", 8'h2a, {1'b0, wiper_pos1});
        $display("test both done");
    endtask

    // Gated writes: one waits for its crossing, the other times out.
    task automatic t_gated();
        wr(CMD_ZC_ON, 8'h0, 8'h0, 0, 1'b0);
        chk("zc on", 8'h1, {7'h0, zc_enabled});
        wr(CMD_WR1, 8'h10, 8'h0, 1, 1'b0);
        chk("pend1", 8'h2, {6'h0, wiper_pending});
        chk("pos1 held", 8'h2a, {1'b0, wiper_pos1});
        terminals_equal = 2'b10;
        repeat (8) @(negedge clk);
        chk("pos1 applied", 8'h10, {1'b0, wiper_pos1});
        chk("pend none", 8'h0, {6'h0, wiper_pending});
        terminals_equal = 2'b00;
        wr(CMD_WR0, 8'h20, 8'h0, 1, 1'b0);
        repeat (100) @(negedge clk);
        chk("pend0", 8'h1, {6'h0, wiper_pending});
        chk("pos0 held", 8'h2a, {1'b0, wiper_pos0});
        repeat (120) @(negedge clk);
        chk("pos0 forced", 8'h20, {1'b0, wiper_pos0});
        chk("pend cleared", 8'h0, {6'h0, wiper_pending});
        chk("pos1 kept", 8'h10, {1'b0, wiper_pos1});
        $display("test gated done");
    endtask

    // Reset for 16 cycles, then let the pin synchronisers settle.
    initial begin
        nrst = 1'b0;
        terminals_equal = 2'b00;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        repeat (10) @(negedge clk);
        t_reset();
        t_refuse();
        t_direct();
        t_both();
        t_gated();
        report_and_stop();
    end
endmodule // dat_i2c_slave_tb
